/* core/llc_loopback_ctrl.sv */
// per-channel loopback selection, datapath steering and diagnostic priority
// assumes all stream inputs are one bit per line-clock cycle on sys_clk,
// detector levels are synchronous, and an APB master drives the registers
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module llc_loopback_ctrl #(
  parameter logic [31:0] PERSIST_CYC = 32'(llc_pkg::PERSIST_CYCLES)
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // in-band code detection levels
  input  wire logic        ib_act_rx,
  input  wire logic        ib_deact_rx,
  input  wire logic        ib_act_tx,
  input  wire logic        ib_deact_tx,
  // data streams
  input  wire logic        line_rx_data,
  input  wire logic        rx_ja_data,
  input  wire logic        rx_dec_data,
  input  wire logic        tx_ja_data,
  input  wire logic        rx_pattern,
  input  wire logic        tx_pattern,
  // diagnostic requests
  input  wire logic        rx_pgen_req,
  input  wire logic        tx_pgen_req,
  input  wire logic        rx_ais_req,
  input  wire logic        tx_ais_req,
  // steering outputs
  output logic             shaper_data,
  output logic             decoder_data,
  output logic             sys_rx_data,
  output logic             analog_loop_sw,
  output logic             tx_clk_ignore,
  output logic             rx_det_looped,
  output logic             pattern_detect_position,
  output logic             auto_loop_active
);
  import llc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // three-level priority select
  function automatic logic prio3(input logic hi_on, input logic hi,
                                 input logic mid_on, input logic mid,
                                 input logic base);
    begin
      prio3 = hi_on ? hi : (mid_on ? mid : base);
    end
  endfunction

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [3:0]  loop_ctrl_q;  // control bits
  logic        pattern_detect_position_q;     // pattern detect position
  logic        pready_q;     // access answer
  logic [31:0] prdata_q;     // read data
  logic        pslverr_q;    // unmapped address
  logic        access;       // access phase
  logic        commit;       // edge where transfer ends
  logic        hit_ctrl;     // control word decode
  logic        hit_pd;       // config word decode
  logic        hit_stat;     // status word decode
  logic        mapped;       // any register hit
  logic [31:0] rd_mux;       // read selection
  logic [31:0] status_word;  // live status

  assign access   = psel && penable;
  assign commit   = access && pready_q;
  assign hit_ctrl = (paddr == LOOP_CTRL_OFS);
  assign hit_pd   = (paddr == PD_CFG_OFS);
  assign hit_stat = (paddr == STATUS_OFS);
  assign mapped   = hit_ctrl || hit_pd || hit_stat;
  assign rd_mux   = hit_ctrl ? {28'h0, loop_ctrl_q} :
                    hit_pd   ? {28'h0, pattern_detect_position_q, 3'h0} :
                    hit_stat ? status_word : 32'h0000_0000;

  // one wait state, answer registered
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= access && !pready_q;
      prdata_q  <= (access && !pready_q && !pwrite) ? rd_mux : prdata_q;
      pslverr_q <= access && !pready_q && !mapped;
    end
  end

  // register writes at the completing edge
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loop_ctrl_q <= LOOP_CTRL_RST;
      pattern_detect_position_q    <= PATTERN_DETECT_POSITION_RST;
    end
    else if (commit && pwrite)
    begin
      if (hit_ctrl)
        loop_ctrl_q <= pwdata[3:0];
      if (hit_pd)
        pattern_detect_position_q <= pwdata[PATTERN_DETECT_POSITION_BIT];
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  logic ana_en;   // analog bit
  logic rem_en;   // manual remote bit
  logic dig_en;   // manual digital bit
  logic auto_en;  // auto loop bit

  assign ana_en  = loop_ctrl_q[ANALOG_BIT];
  assign rem_en  = loop_ctrl_q[REMOTE_BIT];
  assign dig_en  = loop_ctrl_q[DIGITAL_BIT];
  assign auto_en = loop_ctrl_q[AUTO_BIT];

  // ---------------------------------------------------------------
  // code persistence
  // ---------------------------------------------------------------
  logic act_det;    // activate code at selected position
  logic deact_det;  // deactivate code at selected position
  logic act_qual;   // activate held long enough
  logic deact_qual; // deactivate held long enough

  // detector follows the configured path; software holds it steady
  assign act_det   = pattern_detect_position_q ? ib_act_tx : ib_act_rx;
  assign deact_det = pattern_detect_position_q ? ib_deact_tx : ib_deact_rx;

  llc_persist_qual #(
    .LIMIT     (PERSIST_CYC)
  ) u_act_qual (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .enable    (auto_en),
    .det       (act_det),
    .qualified (act_qual)
  );

  llc_persist_qual #(
    .LIMIT     (PERSIST_CYC)
  ) u_deact_qual (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .enable    (auto_en),
    .det       (deact_det),
    .qualified (deact_qual)
  );

  // ---------------------------------------------------------------
  // automatic loop state
  // ---------------------------------------------------------------
  llc_auto_e st_q;  // current state
  llc_auto_e st_d;  // next state

  // entry, exit and forced termination
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      AL_OFF:
      begin
        if (auto_en && !ana_en && !pattern_detect_position_q && !dig_en && act_qual)
          st_d = AL_REMOTE;
        else if (auto_en && !ana_en && pattern_detect_position_q && act_qual)
          st_d = AL_DIGITAL;
      end
      AL_REMOTE:
      begin
        // auto bit cleared, analog set, or digital loop takes the detector
        if (!auto_en || ana_en || dig_en || deact_qual)
          st_d = AL_OFF;
      end
      AL_DIGITAL:
      begin
        if (!auto_en || ana_en || deact_qual)
          st_d = AL_OFF;
      end
      default:
        st_d = AL_OFF;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= AL_OFF;
    else
      st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // effective loop modes
  // ---------------------------------------------------------------
  logic ana_d;    // analog loop
  logic rem_d;    // remote loop, manual or automatic
  logic dig_d;    // digital loop, manual or automatic
  logic adig_d;   // digital loop is automatic
  logic dual_d;   // both remote and digital

  assign ana_d  = ana_en;
  assign rem_d  = !ana_en && (rem_en || (st_q == AL_REMOTE));
  assign dig_d  = !ana_en && (dig_en || (st_q == AL_DIGITAL));
  assign adig_d = !ana_en && !dig_en && (st_q == AL_DIGITAL);
  assign dual_d = rem_d && dig_d;

  // ---------------------------------------------------------------
  // diagnostic permissions
  // ---------------------------------------------------------------
  logic rx_ais_ok;    // rx AIS generation allowed
  logic tx_ais_ok;    // tx AIS generation allowed
  logic tx_pgen_ok;   // tx pattern generation allowed
  logic tx_pgen_top;  // tx pattern beats looped data

  assign rx_ais_ok   = !ana_d && !dig_d;
  assign tx_ais_ok   = !ana_d && !rem_d && !dig_d;
  assign tx_pgen_ok  = !(dual_d && adig_d);
  assign tx_pgen_top = !dual_d;

  // ---------------------------------------------------------------
  // stream steering
  // ---------------------------------------------------------------
  logic tx_src;     // tx data before diagnostics
  logic tx_mid;     // tx after AIS stage
  logic shaper_d;   // to waveform shaper
  logic dec_d;      // to receive decoder
  logic sys_rx_d;   // to system side
  logic shaper_q;   // shaper stream, fed back under analog loop

  // remote takes recovered rx data, system tx data discarded
  assign tx_src = rem_d ? rx_ja_data : tx_ja_data;
  // AIS sits below data whenever a loop is up
  assign tx_mid = prio3(1'b0, 1'b0, tx_ais_ok && tx_ais_req, 1'b1, tx_src);
  // any dual loop sends looped rx data, pattern never wins; otherwise pattern first
  assign shaper_d = tx_pgen_top
                  ? prio3(tx_pgen_ok && tx_pgen_req, tx_pattern, 1'b0, 1'b0, tx_mid)
                  : tx_src;
  // decoder input: digital loop, analog loop, or line
  assign dec_d = dig_d ? tx_ja_data : (ana_d ? shaper_q : line_rx_data);
  // receive pattern always first; AIS only outside analog and digital
  assign sys_rx_d = prio3(rx_pgen_req, rx_pattern, rx_ais_ok && rx_ais_req, 1'b1,
                          rx_dec_data);

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  logic dec_q;        // decoder stream
  logic sys_rx_q;     // system rx stream
  logic ana_q;        // analog switch
  logic rem_q;        // remote loop up
  logic dig_q;        // digital loop up
  logic pd_out_q;     // detect position
  logic auto_act_q;   // automatic loop active

  // registered outputs
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shaper_q   <= 1'b0;
      dec_q      <= 1'b0;
      sys_rx_q   <= 1'b0;
      ana_q      <= 1'b0;
      rem_q      <= 1'b0;
      dig_q      <= 1'b0;
      pd_out_q   <= 1'b0;
      auto_act_q <= 1'b0;
    end
    else
    begin
      shaper_q   <= shaper_d;
      dec_q      <= dec_d;
      sys_rx_q   <= sys_rx_d;
      ana_q      <= ana_d;
      rem_q      <= rem_d;
      dig_q      <= dig_d;
      pd_out_q   <= pattern_detect_position_q;
      auto_act_q <= (st_q != AL_OFF);
    end
  end

  assign shaper_data             = shaper_q;
  assign decoder_data            = dec_q;
  assign sys_rx_data             = sys_rx_q;
  assign analog_loop_sw          = ana_q;
  assign tx_clk_ignore           = rem_q;
  // code detectors see looped data only under digital loop
  assign rx_det_looped           = dig_q;
  // tx detectors are wired to the system input in every mode
  assign pattern_detect_position = pd_out_q;
  assign auto_loop_active        = auto_act_q;

  // status word, unused bits read zero
  assign status_word = {24'h0, auto_act_q, dig_q, rem_q, ana_q, 4'h0};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_analog_excl: assert property (@(posedge sys_clk) disable iff (!reset_n)
    analog_loop_sw |-> !rem_q && !dig_q)
    else $error("loop active alongside analog loop");

  a_manual_remote: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rem_en && !ana_en) |=> rem_q)
    else $error("manual remote loop not entered");

  a_manual_digital: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (dig_en && !ana_en) |=> dig_q)
    else $error("manual digital loop not entered");

  a_auto_remote_in: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q == AL_OFF && auto_en && !ana_en && !pattern_detect_position_q && !dig_en && act_qual)
    |=> (st_q == AL_REMOTE) ##1 rem_q)
    else $error("automatic remote loop not entered");

  a_auto_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q != AL_OFF && !auto_en) |=> (st_q == AL_OFF) ##1 !auto_loop_active)
    else $error("automatic loop survived auto bit clear");

  a_no_auto_rem: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (st_q == AL_REMOTE && dig_en) |=> (st_q != AL_REMOTE))
    else $error("automatic remote loop kept under digital loop");

  a_remote_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rem_d && !tx_pgen_req) |=> (shaper_data == $past(rx_ja_data)))
    else $error("remote loop did not feed recovered data to shaper");

  a_digital_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
    dig_d |=> (decoder_data == $past(tx_ja_data)) && rx_det_looped)
    else $error("digital loop did not feed tx data to decoder");

  a_dual_tx_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (dual_d && !adig_d && tx_pgen_req) |=> (shaper_data == $past(rx_ja_data)))
    else $error("pattern overrode looped data in manual dual loop");

  a_ais_blocked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ana_d && !rx_pgen_req && rx_ais_req) |=> (sys_rx_data == $past(rx_dec_data)))
    else $error("rx AIS generated during analog loop");

endmodule

`default_nettype wire

/* core/llc_persist_qual.sv */
// persistence qualifier for one in-band code detection level
// assumes det is synchronous to sys_clk and held while the code is seen
`timescale 1ns/1ps
`default_nettype none

module llc_persist_qual #(
  parameter logic [31:0] LIMIT = 32'h1E65_FB80
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic enable,   // qualification allowed
  input  wire logic det,      // raw code detection level
  output logic      qualified // code held past the limit
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic [31:0] cnt_q;   // cycles with detection held
  logic [31:0] cnt_d;   // next count
  logic        qual_q;  // qualified flag
  logic        qual_d;  // next flag
  logic        at_lim;  // limit reached

  assign at_lim = (cnt_q >= LIMIT);
  // restart whenever the code drops or loop is not armed
  assign cnt_d  = (!det || !enable) ? 32'h0000_0000 : (at_lim ? cnt_q : cnt_q + 32'h1);
  assign qual_d = det && enable && at_lim;
  assign qualified = qual_q;

  // count register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= 32'h0000_0000;
      qual_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      qual_q <= qual_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_count_restart: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !det |=> (cnt_q == 32'h0000_0000) && !qualified)
    else $error("persistence count did not restart");

endmodule

`default_nettype wire

/* core/llc_pkg.sv */
// constants, field positions and timing counts for the loopback control block
// assumes a single 100 MHz clock and 32-bit APB register access
//
// What this block does
// - analog loop: tx line output into rx input
// - analog loop forces remote and digital off
// - analog: rx pattern wins, AIS generation off
// - manual remote bit enters remote loopback
// - auto remote on rx codes over 5.1s
// - clearing auto bit ends automatic loopback
// - status bit shows automatic loopback active
// - remote: recovered rx data drives shaper
// - remote: tx detectors still watch system data
// - remote: rx pattern over AIS, tx AIS off
// - manual digital bit enters digital loopback
// - auto digital on tx codes over 5.1s
// - digital: tx data feeds decoder, line kept
// - digital: tx pattern, data, then AIS
// - dual only with manual remote loop
// - dual: both streams loop, none pass through
// - dual: detectors split line, looped, system
// - manual dual: tx looped data over pattern
// - auto dual: tx pattern and all AIS off

package llc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] LOOP_CTRL_OFS = 12'h000; // loopback control word
  localparam logic [11:0] PD_CFG_OFS    = 12'h004; // pattern detect config
  localparam logic [11:0] STATUS_OFS    = 12'h008; // channel status

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ANALOG_BIT   = 0; // analog loop enable
  localparam int REMOTE_BIT   = 1; // manual remote loop enable
  localparam int DIGITAL_BIT  = 2; // manual digital loop enable
  localparam int AUTO_BIT     = 3; // auto loop enable
  localparam int PATTERN_DETECT_POSITION_BIT   = 3; // 0 rx path, 1 tx path
  localparam int ST_ANA_BIT   = 4; // effective analog loop
  localparam int ST_REM_BIT   = 5; // effective remote loop
  localparam int ST_DIG_BIT   = 6; // effective digital loop
  localparam int ST_AUTO_BIT  = 7; // automatic loop active

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] LOOP_CTRL_RST = 4'h0; // all loops off
  localparam logic       PATTERN_DETECT_POSITION_RST    = 1'b0; // detector in rx path

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ        = 100000; // system clock rate
  localparam int PERSIST_MS     = 5100;   // code persistence time
  localparam int PERSIST_CYCLES = PERSIST_MS * CLK_KHZ; // exact cycle count, no rounding

  // automatic loop state, one-hot
  typedef enum logic [2:0] {
    AL_OFF     = 3'h1,
    AL_REMOTE  = 3'h2,
    AL_DIGITAL = 3'h4
  } llc_auto_e;

endpackage

/* dv/liu_loopback_control_test.sv */
// self-checking bench for the loopback control block
// assumes llc_pkg, the control block and the far-side stream model
`timescale 1ns/1ps
`default_nettype none

module liu_loopback_control_test;
  import llc_pkg::*;
  localparam logic [31:0] PC = 32'h14; // shortened persistence count
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;    // bus read data, last taken word
  logic        pready, pslverr, err;
  logic        ib_act_rx = 1'b0, ib_deact_rx = 1'b0, ib_act_tx = 1'b0, ib_deact_tx = 1'b0;
  logic        rx_pgen_req = 1'b0, tx_pgen_req = 1'b0, rx_ais_req = 1'b0, tx_ais_req = 1'b0;
  logic        line_rx_data, rx_ja_data, rx_dec_data, tx_ja_data, rx_pattern, tx_pattern;
  logic        shaper_data, decoder_data, sys_rx_data, analog_loop_sw, tx_clk_ignore;
  logic        rx_det_looped, pattern_detect_position, auto_loop_active;
  int          fails = 0;
  int          cmp_count = 0;

  always #5 sys_clk = ~sys_clk; // 100 MHz

  llc_loopback_ctrl #(.PERSIST_CYC(PC)) DUT (
    .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ib_act_rx, .ib_deact_rx, .ib_act_tx, .ib_deact_tx, .line_rx_data,
    .rx_ja_data, .rx_dec_data, .tx_ja_data, .rx_pattern, .tx_pattern, .rx_pgen_req,
    .tx_pgen_req, .rx_ais_req, .tx_ais_req, .shaper_data, .decoder_data, .sys_rx_data,
    .analog_loop_sw, .tx_clk_ignore, .rx_det_looped, .pattern_detect_position,
    .auto_loop_active
  );
  llc_far_model far_side (
    .sys_clk, .reset_n, .line_rx_data, .rx_ja_data, .rx_dec_data, .tx_ja_data,
    .rx_pattern, .tx_pattern
  );

  // ------------------------------
  // compare and closing tasks
  // ------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------
  // bus access
  // ------------------------------
  // setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1 && n++ < 20);
    if (n >= 20)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk_word("prdata", e, rd);
    chk_bit("pslverr", ee, err);
  endtask

  // ------------------------------
  // stream steering check
  // ------------------------------
  // sweeps all request combinations; outputs lag inputs by one edge
  task automatic run(input logic rem, input logic dig, input logic ana);
    logic es, er, ed;
    for (int i = 0; i < 34; i++)
    begin
      @(posedge sys_clk);
      {rx_pgen_req, tx_pgen_req, rx_ais_req, tx_ais_req} <= 4'(i >> 1);
      #1;
      if (i > 1)
      begin
        chk_bit("shaper_data", es, shaper_data);
        chk_bit("sys_rx_data", er, sys_rx_data);
        chk_bit("decoder_data", ed, decoder_data);
      end
      if (rem && dig && !ana)
        es = rx_ja_data;
      else if (rem && !ana)
        es = tx_pgen_req ? tx_pattern : rx_ja_data;
      else
        es = tx_pgen_req ? tx_pattern : ((tx_ais_req && !ana && !dig) ? 1'b1 : tx_ja_data);
      er = rx_pgen_req ? rx_pattern : ((rx_ais_req && !ana && !dig) ? 1'b1 : rx_dec_data);
      ed = dig ? tx_ja_data : (ana ? shaper_data : line_rx_data);
    end
    @(posedge sys_clk);
  endtask

  // waits for the automatic flag; the delay must fall in lo..hi
  task automatic wait_auto(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (auto_loop_active !== lvl && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_bit("auto_loop_active", lvl, auto_loop_active);
    chk_bit("auto_delay_ok", 1'b1, n >= lo && n <= hi);
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    chk_word("outputs_in_reset", 32'h0, {24'h0, shaper_data, decoder_data, sys_rx_data,
             analog_loop_sw, tx_clk_ignore, rx_det_looped, pattern_detect_position,
             auto_loop_active});
    reset_n <= 1'b1;
    rdc(LOOP_CTRL_OFS, 32'h0, 1'b0);
    rdc(STATUS_OFS, 32'h0, 1'b0);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk_bit("wr_slverr", 1'b1, err);
    rdc(12'h00C, 32'h0, 1'b1);
    apb(1'b1, PD_CFG_OFS, 32'hFFFF_FFFF);
    rdc(PD_CFG_OFS, 32'h8, 1'b0);
    chk_bit("pattern_detect_position", 1'b1, pattern_detect_position);
    apb(1'b1, PD_CFG_OFS, 32'h0);
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    rdc(STATUS_OFS, 32'h0, 1'b0);
    apb(1'b1, LOOP_CTRL_OFS, 32'hFFFF_FFF7);
    rdc(LOOP_CTRL_OFS, 32'h7, 1'b0);
    rdc(STATUS_OFS, 32'h1 << ST_ANA_BIT, 1'b0);
    chk_word("analog_modes", 32'h4, {analog_loop_sw, tx_clk_ignore, rx_det_looped});
    run(1'b0, 1'b0, 1'b1);
    apb(1'b1, LOOP_CTRL_OFS, 32'h2);
    rdc(STATUS_OFS, 32'h1 << ST_REM_BIT, 1'b0);
    chk_bit("tx_clk_ignore", 1'b1, tx_clk_ignore);
    run(1'b1, 1'b0, 1'b0);
    apb(1'b1, LOOP_CTRL_OFS, 32'h4);
    rdc(STATUS_OFS, 32'h1 << ST_DIG_BIT, 1'b0);
    chk_bit("rx_det_looped", 1'b1, rx_det_looped);
    run(1'b0, 1'b1, 1'b0);
    apb(1'b1, LOOP_CTRL_OFS, 32'h6);
    run(1'b1, 1'b1, 1'b0);
    apb(1'b1, LOOP_CTRL_OFS, 32'h0);
    run(1'b0, 1'b0, 1'b0);
    // automatic remote, with a detection dropout restarting the count
    apb(1'b1, LOOP_CTRL_OFS, 32'h8);
    @(posedge sys_clk);
    ib_act_rx <= 1'b1;
    repeat (15) @(posedge sys_clk);
    ib_act_rx <= 1'b0;
    @(posedge sys_clk);
    ib_act_rx <= 1'b1;
    wait_auto(1'b1, PC, PC + 8);
    ib_act_rx <= 1'b0;
    rdc(STATUS_OFS, (32'h1 << ST_REM_BIT) | (32'h1 << ST_AUTO_BIT), 1'b0);
    ib_deact_rx <= 1'b1;
    wait_auto(1'b0, PC, PC + 8);
    ib_deact_rx <= 1'b0;
    ib_act_rx <= 1'b1;
    wait_auto(1'b1, PC, PC + 8);
    ib_act_rx <= 1'b0;
    apb(1'b1, LOOP_CTRL_OFS, 32'h0);
    wait_auto(1'b0, 0, 3);
    repeat (2) @(posedge sys_clk);
    chk_bit("tx_clk_ignore", 1'b0, tx_clk_ignore);
    // no automatic remote while digital loop is up
    apb(1'b1, LOOP_CTRL_OFS, 32'hC);
    ib_act_rx <= 1'b1;
    repeat (PC + 12) @(posedge sys_clk);
    chk_bit("auto_loop_active", 1'b0, auto_loop_active);
    ib_act_rx <= 1'b0;
    rdc(STATUS_OFS, 32'h1 << ST_DIG_BIT, 1'b0);
    // automatic digital, then dual with manual remote
    apb(1'b1, PD_CFG_OFS, 32'h8);
    apb(1'b1, LOOP_CTRL_OFS, 32'h8);
    ib_act_tx <= 1'b1;
    wait_auto(1'b1, PC, PC + 8);
    ib_act_tx <= 1'b0;
    rdc(STATUS_OFS, (32'h1 << ST_DIG_BIT) | (32'h1 << ST_AUTO_BIT), 1'b0);
    apb(1'b1, LOOP_CTRL_OFS, 32'hA);
    run(1'b1, 1'b1, 1'b0);
    ib_deact_tx <= 1'b1;
    wait_auto(1'b0, PC, PC + 8);
    ib_deact_tx <= 1'b0;
    finish_test();
  end

  // hang guard, far above the expected run length
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    finish_test();
  end
endmodule

`default_nettype wire

/* dv/llc_far_model.sv */
// far-side stream source: line, attenuator, decoder and pattern bits
// assumes the bench clock and reset; every bit moves each cycle
`timescale 1ns/1ps
`default_nettype none

module llc_far_model (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  output logic      line_rx_data,
  output logic      rx_ja_data,
  output logic      rx_dec_data,
  output logic      tx_ja_data,
  output logic      rx_pattern,
  output logic      tx_pattern
);
  logic [7:0] lfsr_q; // shared shift register

  // ------------------------------
  // stream generator
  // ------------------------------
  // fresh bits each cycle so a stale or swapped stream shows up
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      lfsr_q <= 8'hA5;
    else
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  assign line_rx_data = lfsr_q[0];             // raw line bit
  assign rx_ja_data   = lfsr_q[2] ^ lfsr_q[5]; // after rx attenuator
  assign rx_dec_data  = lfsr_q[1] ^ lfsr_q[6]; // decoder output
  assign tx_ja_data   = lfsr_q[3] ^ lfsr_q[7]; // after tx attenuator
  assign rx_pattern   = lfsr_q[4] ^ lfsr_q[0]; // rx generator bit
  assign tx_pattern   = ~lfsr_q[6];            // tx generator bit
endmodule

`default_nettype wire
